// *** include/nvm_port_pkg.sv ***
// Package: constants for the lock, fuse and parallel program port block
package nvm_port_pkg;
  // Lock byte bit positions
  localparam int LOCK_MEM_A_BIT  = 0;
  localparam int LOCK_MEM_B_BIT  = 1;
  localparam int LOCK_APP_LO_BIT = 2;
  localparam int LOCK_APP_HI_BIT = 3;
  localparam int LOCK_BOOT_LO_BIT = 4;
  localparam int LOCK_BOOT_HI_BIT = 5;
  localparam logic [5:0] LOCK_RESET = 6'h3F;
  // Fuse byte bit positions
  localparam int FUSE_BOOT_RST_BIT = 6;
  localparam int FUSE_SERIAL_BIT   = 5;
  localparam int FUSE_SUT_BIT      = 4;
  localparam logic [7:0] FUSE_RESET = 8'hDA;
  localparam logic [7:0] FUSE_KEEP  = 8'h88;
  // Reset vectors
  localparam logic [15:0] BOOT_VECTOR = 16'h1E00;
  localparam logic [15:0] ZERO_VECTOR = 16'h0000;
  // Strobe action codes
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  // Command bytes
  localparam logic [7:0] CMD_ERASE     = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE   = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK   = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH  = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] CMD_RD_ID     = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE   = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH  = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM = 8'h03;
  // Page geometry
  localparam int PAGE_COUNT = 128;
  localparam int PAGE_BYTES = 128;
  // Identity bytes: arbitrary values
  localparam logic [7:0] ID_BYTE0 = 8'h5A;
  localparam logic [7:0] ID_BYTE1 = 8'hA5;
  localparam logic [7:0] ID_BYTE2 = 8'h3C;
  // Timing
  localparam int CLK_NS        = 50;
  localparam int PULSE_MIN_NS  = 500;
  localparam int PULSE_CYCLES  = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_US       = 4;
  localparam int BUSY_CYCLES   = (BUSY_US * 1000) / CLK_NS;
  localparam int ERASE_US      = 40;
  localparam int ERASE_CYCLES  = (ERASE_US * 1000) / CLK_NS;
  localparam int FIFO_DEPTH    = 4;
  localparam int FIFO_WIDTH    = 8;
endpackage : nvm_port_pkg

// *** include/byte_stream_if.sv ***
// Interface: valid/ready byte stream between internal modules
`timescale 1ns/1ns
`default_nettype none
interface byte_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface : byte_stream_if
`default_nettype wire

// *** logic/byte_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic    ref_clk,
  input  wire logic    arst_n,
  byte_stream_if.sink   in_s,
  byte_stream_if.source out_s
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be power of 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  always_comb begin
    full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    empty       = (wr_ptr == rd_ptr);
    push        = in_s.valid && !full;
    pop         = out_s.ready && !empty;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_s.data;
    end
  end

  assign in_s.ready  = !full;
  assign out_s.valid = !empty;
  assign out_s.data  = mem[rd_ptr[AW-1:0]];

  a_fifo_push_held: assert property (@(posedge ref_clk) disable iff (!arst_n)
    push |=> !empty) else $error("FIFO lost a pushed word");
endmodule : byte_fifo
`default_nettype wire

// *** logic/strobe_sync.sv ***
// Two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ns
`default_nettype none
module strobe_sync #(
  parameter int               WIDTH = 1,
  // Reset level per bit: must match the pin's idle level, or a false
  // edge follows reset
  parameter logic [WIDTH-1:0] IDLE  = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;

  // Only the second stage and later are read by logic
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= IDLE;
      sync <= IDLE;
      prev <= IDLE;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level = sync;
  assign rise  = sync & ~prev;
  assign fall  = ~sync & prev;
endmodule : strobe_sync
`default_nettype wire

// *** logic/nvm_program_port.sv ***
// Lock/fuse store and high-voltage parallel program port front end
// Overview of operation
// (R1) Six lock bits, 1 unprogrammed; only chip erase returns them to 1. The code also reloads LOCK_RESET on arst_n.
// (R2) Lock mode 2: refuse flash/EEPROM writes, freeze fuses.
// (R3) Lock mode 3: refuse writes and read-back, fuses frozen.
// (R4) App lock 1/0: self-program writes to app area blocked.
// (R5) App lock 0/0: block app writes and boot-area reads of app.
// (R6) App lock 0/1: block boot-area reads of app, writes allowed.
// (R7) Boot lock 1/0: self-program writes to boot area blocked.
// (R8) Boot lock 0/0: block boot writes and app-area reads of boot.
// (R9) Boot lock 0/1: block app-area reads of boot, writes allowed.
// (R10) Boot-reset fuse 0 gives boot vector, else vector zero.
// (R11) Serial download fuse defaults to 0, unreachable from serial mode.
// (R12) Start-up fuse defaults 1, clock select fuses default 010.
// (R13) Chip erase keeps fuses; fuses frozen when any memory lock set.
// (R14) Programmer should write fuses before programming locks.
// (R15) Three identity bytes at addresses 0 to 2.
// (R16) Flash is 128 pages of 128 bytes, committed page-wise.
// (R17) Programmer strobe pulses last at least 500 ns.
// (R18) Crystal strobe rising edge performs action-select action.
// (R19) Write or output-enable low pulse runs loaded command.
// (R20) Busy/ready low while programming, high when ready.
// (R21) Byte select a picks low/high byte; byte select b held low.
// (R22) Data port drives only while output enable is low.
// (R23) Action codes: address, data, command, idle.
// (R24) Command codes for erase, fuses, locks, flash, EEPROM, identity.
// (R25) Page latch pulse stores current data byte into page buffer.
// (R26) Data port released while output enable is high.
`timescale 1ns/1ns
`default_nettype none
module nvm_program_port
  import nvm_port_pkg::*;
#(
  parameter int BUSY_CYC  = BUSY_CYCLES,
  parameter int ERASE_CYC = ERASE_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // Programmer pins
  input  wire logic        crystal_in_strobe,
  input  wire logic        strobe_action_0,
  input  wire logic        strobe_action_1,
  input  wire logic        byte_select_a,
  input  wire logic        byte_select_b,
  input  wire logic        page_latch_strobe,
  input  wire logic        write_n,
  input  wire logic        output_enable_n,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  output logic             busy_ready_out,
  // Memory array side
  output logic             page_commit,
  output logic [6:0]       page_index,
  output logic             page_byte_valid,
  output logic [7:0]       page_byte,
  input  wire logic        page_byte_ready,
  output logic             eeprom_write,
  output logic [15:0]      mem_addr,
  output logic [7:0]       eeprom_data,
  output logic             array_erase,
  input  wire logic [7:0]  read_data,
  // Self-programming access checks
  input  wire logic        self_wr_app,
  input  wire logic        self_wr_boot,
  input  wire logic        table_rd_boot_to_app,
  input  wire logic        table_rd_app_to_boot,
  output logic             self_wr_allow,
  output logic             table_rd_allow,
  // Fuse and lock state
  output logic [5:0]       lock_bits,
  output logic             boot_reset_fuse,
  output logic             serial_download_fuse,
  output logic             startup_time_fuse,
  output logic [2:0]       clock_select_fuse,
  output logic [15:0]      reset_vector,
  output logic             refused
);
  initial begin
    if (BUSY_CYC < 2 || ERASE_CYC < 1) $error("Busy count must be >= 2");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_lvl;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;
  logic [7:0] data_meta;
  logic [7:0] data_sync;
  logic [3:0] ctl_meta;
  logic [3:0] ctl_sync;

  // Write and output-enable idle high
  strobe_sync #(.WIDTH(5), .IDLE(5'h06)) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .pin     ({crystal_in_strobe, page_latch_strobe, write_n,
               output_enable_n, byte_select_b}),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_meta <= 8'h00;
      data_sync <= 8'h00;
      ctl_meta  <= 4'h0;
      ctl_sync  <= 4'h0;
    end else begin
      data_meta <= data_in;
      data_sync <= data_meta;
      ctl_meta  <= {strobe_action_1, strobe_action_0, byte_select_a, 1'b0};
      ctl_sync  <= ctl_meta;
    end
  end

  logic       xtal_rise;
  logic       page_latch_strobe_rise;
  logic       wr_fall;
  logic       oe_low;
  logic [1:0] action;
  logic       hi_byte;
  assign xtal_rise  = pin_rise[4];
  assign page_latch_strobe_rise = pin_rise[3];
  assign wr_fall    = pin_fall[2];
  assign oe_low     = ~pin_lvl[1];
  assign action     = ctl_sync[3:2];
  assign hi_byte    = ctl_sync[1] & ~pin_lvl[0]; // R21

  // ----------------------------------------------------------------
  // Page buffer FIFO
  // ----------------------------------------------------------------
  byte_stream_if #(.WIDTH(FIFO_WIDTH)) fifo_in ();
  byte_stream_if #(.WIDTH(FIFO_WIDTH)) fifo_out ();

  byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .in_s    (fifo_in.sink),
    .out_s   (fifo_out.source)
  );

  // ----------------------------------------------------------------
  // Port state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BUSY  = 2'b01,
    ST_DRAIN = 2'b10
  } state_type;

  state_type   state;
  state_type   next_state;
  logic [7:0]  cmd;
  logic [7:0]  next_cmd;
  logic [15:0] addr;
  logic [15:0] next_addr;
  logic [7:0]  data_lo;
  logic [7:0]  next_data_lo;
  logic [7:0]  data_hi;
  logic [7:0]  next_data_hi;
  logic [5:0]  lock;
  logic [5:0]  next_lock;
  logic [7:0]  fuse;
  logic [7:0]  next_fuse;
  logic [15:0] busy_cnt;
  logic [15:0] next_busy_cnt;
  logic        erase_pend;
  logic        next_erase_pend;
  logic        refuse;
  logic        next_refuse;
  logic        commit;
  logic        next_commit;
  logic        ee_wr;
  logic        next_ee_wr;
  logic        erase;
  logic        next_erase;
  logic        fifo_push;
  logic [7:0]  push_byte;

  // Lock decode
  logic mem_lock_a;
  logic mem_lock_b;
  logic app_sect_lock_lo;
  logic app_sect_lock_hi;
  logic boot_sect_lock_lo;
  logic boot_sect_lock_hi;
  logic wr_block;
  logic rd_block;
  logic fuse_frozen;
  assign mem_lock_a        = lock[LOCK_MEM_A_BIT];
  assign mem_lock_b        = lock[LOCK_MEM_B_BIT];
  assign app_sect_lock_lo  = lock[LOCK_APP_LO_BIT];
  assign app_sect_lock_hi  = lock[LOCK_APP_HI_BIT];
  assign boot_sect_lock_lo = lock[LOCK_BOOT_LO_BIT];
  assign boot_sect_lock_hi = lock[LOCK_BOOT_HI_BIT];
  assign wr_block    = ~mem_lock_a;                  // R2
  assign rd_block    = ~mem_lock_a & ~mem_lock_b;    // R3
  assign fuse_frozen = ~mem_lock_a | ~mem_lock_b;    // R13

  always_comb begin
    next_state      = state;
    next_cmd        = cmd;
    next_addr       = addr;
    next_data_lo    = data_lo;
    next_data_hi    = data_hi;
    next_lock       = lock;
    next_fuse       = fuse;
    next_busy_cnt   = busy_cnt;
    next_erase_pend = erase_pend;
    next_refuse     = refuse;
    next_commit     = 1'b0;
    next_ee_wr      = 1'b0;
    next_erase      = 1'b0;
    fifo_push       = 1'b0;
    push_byte       = hi_byte ? data_hi : data_lo;
    if (xtal_rise) begin // R18
      unique case (action) // R23
        ACT_ADDR: begin
          if (hi_byte) next_addr[15:8] = data_sync;
          else         next_addr[7:0]  = data_sync;
        end
        ACT_DATA: begin
          if (hi_byte) next_data_hi = data_sync;
          else         next_data_lo = data_sync;
        end
        ACT_CMD:  next_cmd = data_sync;
        ACT_IDLE: ;
      endcase
    end
    // Programmer must not latch while the buffer is full
    if (page_latch_strobe_rise && state == ST_IDLE) begin
      fifo_push = 1'b1; // R25
    end
    unique case (state)
      ST_IDLE: begin
        if (wr_fall) begin // R19
          next_refuse = 1'b0;
          unique case (cmd) // R24
            CMD_ERASE: begin
              next_erase      = 1'b1;
              next_erase_pend = 1'b1;
              next_busy_cnt   = 16'(ERASE_CYC);
              next_state      = ST_BUSY;
            end
            CMD_WR_FUSE: begin
              if (fuse_frozen) next_refuse = 1'b1; // R13
              else begin
                // Reserved bits stay at 1
                next_fuse     = data_lo | FUSE_KEEP;
                next_busy_cnt = 16'(BUSY_CYC);
                next_state    = ST_BUSY;
              end
            end
            CMD_WR_LOCK: begin
              // Programming only clears bits, never sets them
              next_lock     = lock & data_lo[5:0]; // R1
              next_busy_cnt = 16'(BUSY_CYC);
              next_state    = ST_BUSY;
            end
            CMD_WR_FLASH: begin
              if (wr_block) next_refuse = 1'b1; // R2
              else begin
                next_commit   = 1'b1; // R16
                next_busy_cnt = 16'(BUSY_CYC);
                next_state    = ST_DRAIN;
              end
            end
            CMD_WR_EEPROM: begin
              if (wr_block) next_refuse = 1'b1; // R2
              else begin
                next_ee_wr    = 1'b1;
                next_busy_cnt = 16'(BUSY_CYC);
                next_state    = ST_BUSY;
              end
            end
            default: ;
          endcase
        end
      end
      ST_DRAIN: begin
        // Commit pulses on entry; busy countdown waits until queued bytes reached the page buffer
        if (!fifo_out.valid) next_state = ST_BUSY;
      end
      ST_BUSY: begin
        if (busy_cnt <= 16'h0001) begin
          next_busy_cnt = 16'h0000;
          next_state    = ST_IDLE;
          if (erase_pend) begin
            next_lock       = LOCK_RESET; // R1
            next_erase_pend = 1'b0;
          end
        end else begin
          next_busy_cnt = busy_cnt - 16'h0001;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_IDLE;
      cmd        <= 8'h00;
      addr       <= 16'h0000;
      data_lo    <= 8'hFF;
      data_hi    <= 8'hFF;
      lock       <= LOCK_RESET;
      fuse       <= FUSE_RESET; // R12 R11
      busy_cnt   <= 16'h0000;
      erase_pend <= 1'b0;
      refuse     <= 1'b0;
      commit     <= 1'b0;
      ee_wr      <= 1'b0;
      erase      <= 1'b0;
    end else begin
      state      <= next_state;
      cmd        <= next_cmd;
      addr       <= next_addr;
      data_lo    <= next_data_lo;
      data_hi    <= next_data_hi;
      lock       <= next_lock;
      fuse       <= next_fuse;
      busy_cnt   <= next_busy_cnt;
      erase_pend <= next_erase_pend;
      refuse     <= next_refuse;
      commit     <= next_commit;
      ee_wr      <= next_ee_wr;
      erase      <= next_erase;
    end
  end

  assign fifo_in.valid  = fifo_push;
  assign fifo_in.data   = push_byte;
  assign fifo_out.ready = page_byte_ready;

  // ----------------------------------------------------------------
  // Read mux and registered outputs
  // ----------------------------------------------------------------
  logic [7:0] next_rd;
  logic       next_sw_allow;
  logic       next_tr_allow;

  always_comb begin
    next_rd = 8'hFF;
    unique case (cmd)
      CMD_RD_ID: begin // R15
        unique case (addr[1:0])
          2'h0:    next_rd = ID_BYTE0;
          2'h1:    next_rd = ID_BYTE1;
          2'h2:    next_rd = ID_BYTE2;
          default: next_rd = 8'hFF;
        endcase
      end
      CMD_RD_FUSE:   next_rd = hi_byte ? {2'b11, lock} : fuse;
      CMD_RD_FLASH,
      CMD_RD_EEPROM: next_rd = rd_block ? 8'hFF : read_data; // R3
      default:       next_rd = 8'hFF;
    endcase
    // R4 R5 R7 R8
    next_sw_allow = !(self_wr_app && !app_sect_lock_lo)
                 && !(self_wr_boot && !boot_sect_lock_lo);
    // R5 R6 R8 R9
    next_tr_allow = !(table_rd_boot_to_app && !app_sect_lock_hi)
                 && !(table_rd_app_to_boot && !boot_sect_lock_hi);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out        <= 8'h00;
      data_oe         <= 1'b0;
      busy_ready_out  <= 1'b1;
      self_wr_allow   <= 1'b1;
      table_rd_allow  <= 1'b1;
      reset_vector    <= ZERO_VECTOR;
    end else begin
      data_out        <= next_rd;
      data_oe         <= oe_low; // R22 R26
      busy_ready_out  <= (next_state == ST_IDLE); // R20
      self_wr_allow   <= next_sw_allow;
      table_rd_allow  <= next_tr_allow;
      reset_vector    <= fuse[FUSE_BOOT_RST_BIT] ? ZERO_VECTOR
                                                 : BOOT_VECTOR; // R10
    end
  end

  assign page_commit          = commit;
  assign page_index           = {addr[12:8], addr[7:6]};
  assign page_byte_valid      = fifo_out.valid;
  assign page_byte            = fifo_out.data;
  assign eeprom_write         = ee_wr;
  assign mem_addr             = addr;
  assign eeprom_data          = data_lo;
  assign array_erase          = erase;
  assign lock_bits            = lock;
  assign boot_reset_fuse      = fuse[FUSE_BOOT_RST_BIT];
  assign serial_download_fuse = fuse[FUSE_SERIAL_BIT];
  assign startup_time_fuse    = fuse[FUSE_SUT_BIT];
  assign clock_select_fuse    = fuse[2:0];
  assign refused              = refuse;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_lock_only_clears: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !erase_pend |=> ((lock & ~$past(lock)) == 6'h00)) // R1
    else $error("Lock bit returned to 1 without erase");
  a_flash_wr_refused: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state == ST_IDLE && wr_fall && cmd == CMD_WR_FLASH && wr_block)
    |=> refused && !page_commit) // R2
    else $error("Flash write not refused under lock");
  a_readback_blocked: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (rd_block && cmd == CMD_RD_FLASH) |=> data_out == 8'hFF) // R3
    else $error("Read-back not blocked");
  a_fuse_frozen: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fuse_frozen |=> $stable(fuse)) // R13
    else $error("Fuses changed while frozen");
  a_app_write_lock: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (self_wr_app && !app_sect_lock_lo) |=> !self_wr_allow) // R4
    else $error("Self write to app area allowed");
  a_boot_read_lock: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (table_rd_app_to_boot && !boot_sect_lock_hi) |=> !table_rd_allow) // R9
    else $error("Table read of boot area allowed");
  a_reset_vector: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !boot_reset_fuse |=> reset_vector == BOOT_VECTOR) // R10
    else $error("Wrong reset vector");
  a_busy_on_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state == ST_IDLE && wr_fall && cmd == CMD_WR_LOCK)
    |=> !busy_ready_out ##1 !busy_ready_out) // R20
    else $error("Busy not shown during programming");
  a_data_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
    pin_lvl[1] |=> !data_oe) // R26
    else $error("Data port driven with output enable high");
  a_cmd_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (xtal_rise && action == ACT_CMD) |=> cmd == $past(data_sync)) // R18
    else $error("Command byte not loaded");

  c_erase: cover property (@(posedge ref_clk) wr_fall && cmd == CMD_ERASE);
  c_commit: cover property (@(posedge ref_clk) page_commit);
  c_refuse: cover property (@(posedge ref_clk) refused);
  c_id_read: cover property (@(posedge ref_clk)
    data_oe && cmd == CMD_RD_ID);
endmodule : nvm_program_port
`default_nettype wire

// *** tb/nvm_array_model.sv ***
// Memory array stand-in: drains the page stream slowly, answers reads
`timescale 1ns/1ns
`default_nettype none
module nvm_array_model (
  input  wire logic        ref_clk,
  input  wire logic        stall,
  input  wire logic        page_byte_valid,
  input  wire logic [7:0]  page_byte,
  input  wire logic [15:0] mem_addr,
  output logic             page_byte_ready,
  output logic [7:0]       read_data,
  output logic [7:0]       last_byte,
  output int               n_rx
);
  logic tick = 1'b0;
  initial n_rx = 0;
  // Ready only every other cycle, so the FIFO never drains at full rate
  assign page_byte_ready = tick & ~stall;
  assign read_data = ~mem_addr[7:0];
  always @(posedge ref_clk) begin
    tick <= ~tick;
    if (page_byte_valid && page_byte_ready) begin
      last_byte <= page_byte;
      n_rx <= n_rx + 1;
    end
  end
endmodule : nvm_array_model
`default_nettype wire

// *** tb/memory_lock_and_parallel_program_port_tb_top.sv ***
// Testbench: parallel programmer sequences against the program port
`timescale 1ns/1ns
`default_nettype none
module memory_lock_and_parallel_program_port_tb_top
  import nvm_port_pkg::*;
;
  logic ref_clk = 1'b0, arst_n = 1'b0, crystal_in_strobe = 1'b0;
  logic strobe_action_0 = 1'b1, strobe_action_1 = 1'b1;
  logic byte_select_a = 1'b0, byte_select_b = 1'b0, write_n = 1'b1;
  logic page_latch_strobe = 1'b0, output_enable_n = 1'b1, stall = 1'b0;
  logic self_wr_app = 1'b0, self_wr_boot = 1'b0;
  logic table_rd_boot_to_app = 1'b0, table_rd_app_to_boot = 1'b0;
  logic [7:0] pin_drv = 8'hFF, data_in, data_out, page_byte;
  logic [7:0] eeprom_data, read_data, last_byte;
  logic [15:0] mem_addr, reset_vector;
  logic [6:0] page_index;
  logic [5:0] lock_bits;
  logic [2:0] clock_select_fuse;
  logic data_oe, busy_ready_out, page_commit, page_byte_valid;
  logic page_byte_ready, eeprom_write, array_erase, self_wr_allow;
  logic table_rd_allow, boot_reset_fuse, serial_download_fuse;
  logic startup_time_fuse, refused;
  logic [7:0] ids [3] = '{ID_BYTE0, ID_BYTE1, ID_BYTE2};
  int n_errors = 0, cmp_count = 0, n_rx, cycles = 0;
  logic [2:0] seen = 3'h0;
  // Shared pin: device wins only while it enables its drivers
  assign data_in = data_oe ? data_out : pin_drv;
  always #25 ref_clk = ~ref_clk;
  nvm_program_port #(.BUSY_CYC(20), .ERASE_CYC(40)) i_dut (.ref_clk,
    .arst_n, .crystal_in_strobe, .strobe_action_0, .strobe_action_1,
    .byte_select_a, .byte_select_b, .page_latch_strobe, .write_n,
    .output_enable_n, .data_in, .data_out, .data_oe, .busy_ready_out,
    .page_commit, .page_index, .page_byte_valid, .page_byte,
    .page_byte_ready, .eeprom_write, .mem_addr, .eeprom_data,
    .array_erase, .read_data, .self_wr_app, .self_wr_boot,
    .table_rd_boot_to_app, .table_rd_app_to_boot, .self_wr_allow,
    .table_rd_allow, .lock_bits, .boot_reset_fuse, .serial_download_fuse,
    .startup_time_fuse, .clock_select_fuse, .reset_vector, .refused);
  nvm_array_model i_model (.ref_clk, .stall, .page_byte_valid,
    .page_byte, .mem_addr, .page_byte_ready, .read_data, .last_byte,
    .n_rx);
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task results;
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Every pulse is 12 cycles, above the 500 ns minimum
  task strobe(input logic [1:0] a, input logic b, input logic [7:0] d);
    {strobe_action_1, strobe_action_0} = a;
    byte_select_a = b;
    pin_drv = d;
    cyc(12);
    crystal_in_strobe = 1'b1;
    cyc(12);
    crystal_in_strobe = 1'b0;
    cyc(12);
  endtask : strobe
  task wr(input logic idle);
    int i;
    write_n = 1'b0;
    cyc(8);
    chk(busy_ready_out, idle);
    cyc(4);
    write_n = 1'b1;
    for (i = 0; i < 2000 && busy_ready_out !== 1'b1; i++) cyc(1);
    chk(busy_ready_out, 1'b1);
  endtask : wr
  task rd(input logic [7:0] e);
    output_enable_n = 1'b0;
    cyc(12);
    chk(data_oe, 1'b1);
    chk(data_out, e);
    output_enable_n = 1'b1;
    cyc(6);
    chk(data_oe, 1'b0);
  endtask : rd
  always @(posedge ref_clk) begin
    cycles++;
    seen <= seen | {page_commit, array_erase, eeprom_write};
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    cyc(20);
    arst_n = 1'b1;
    chk(lock_bits, LOCK_RESET);
    chk({boot_reset_fuse, serial_download_fuse}, 2'b10);
    chk({startup_time_fuse, clock_select_fuse}, 4'hA);
    chk(reset_vector, ZERO_VECTOR);
    cyc(2);
    chk(data_oe, 1'b0);
    strobe(ACT_CMD, 1'b0, CMD_RD_ID);
    for (int i = 0; i < 3; i++) begin
      strobe(ACT_ADDR, 1'b0, 8'(i));
      rd(ids[i]);
    end
    strobe(ACT_IDLE, 1'b0, 8'h00);
    rd(ID_BYTE2);
    strobe(ACT_CMD, 1'b0, CMD_WR_FLASH);
    strobe(ACT_ADDR, 1'b1, 8'h1F);
    strobe(ACT_ADDR, 1'b0, 8'hC0);
    stall = 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      strobe(ACT_DATA, 1'b0, 8'h10 + 8'(i));
      page_latch_strobe = 1'b1;
      cyc(12);
      page_latch_strobe = 1'b0;
      cyc(12);
    end
    chk(page_byte_valid, 1'b1);
    stall = 1'b0;
    cyc(30);
    chk(16'(n_rx), 16'(FIFO_DEPTH));
    chk(last_byte, 8'h13);
    wr(1'b0);
    chk({page_index, seen}, 10'h3FC);
    strobe(ACT_CMD, 1'b0, CMD_WR_EEPROM);
    strobe(ACT_ADDR, 1'b1, 8'h01);
    strobe(ACT_ADDR, 1'b0, 8'h22);
    strobe(ACT_DATA, 1'b0, 8'h77);
    wr(1'b0);
    chk(mem_addr, 16'h0122);
    chk({eeprom_data, seen}, 11'h3BD);
    strobe(ACT_CMD, 1'b0, CMD_WR_FUSE);
    strobe(ACT_DATA, 1'b0, 8'h8A);
    wr(1'b0);
    chk(reset_vector, BOOT_VECTOR);
    chk(startup_time_fuse, 1'b0);
    strobe(ACT_CMD, 1'b0, CMD_RD_FUSE);
    rd(8'h8A);
    strobe(ACT_CMD, 1'b0, CMD_WR_LOCK);
    strobe(ACT_DATA, 1'b0, 8'h18);
    wr(1'b0);
    chk(lock_bits, 6'h18);
    self_wr_app = 1'b1;
    table_rd_boot_to_app = 1'b1;
    cyc(3);
    chk(self_wr_allow, 1'b0);
    chk(table_rd_allow, 1'b1);
    self_wr_app = 1'b0;
    table_rd_boot_to_app = 1'b0;
    {self_wr_boot, table_rd_app_to_boot} = 2'h3;
    cyc(3);
    chk({self_wr_allow, table_rd_allow}, 2'h2);
    strobe(ACT_CMD, 1'b0, CMD_WR_FUSE);
    strobe(ACT_DATA, 1'b0, 8'hCA);
    wr(1'b1);
    chk(refused, 1'b1);
    chk(reset_vector, BOOT_VECTOR);
    strobe(ACT_CMD, 1'b0, CMD_WR_FLASH);
    wr(1'b1);
    chk({refused, seen}, 4'hD);
    strobe(ACT_CMD, 1'b0, CMD_RD_FLASH);
    rd(8'hFF);
    strobe(ACT_CMD, 1'b0, CMD_ERASE);
    wr(1'b0);
    chk(lock_bits, LOCK_RESET);
    chk(reset_vector, BOOT_VECTOR);
    cyc(1);
    chk({self_wr_allow, table_rd_allow, seen}, 5'h1F);
    results();
  end
endmodule : memory_lock_and_parallel_program_port_tb_top
`default_nettype wire
